// [inc/variable_latency_io_pkg.sv]
// Shared constants for the variable latency io port
`default_nettype none
package variable_latency_io_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Chip select lead time before first strobe, in ns
    localparam int unsigned CS_LEAD_NS    = 8;
    localparam int unsigned CS_LEAD_CYC   =
        (CS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_W        = 26;
    localparam int unsigned CNT_W         = 4;
    localparam int unsigned LEN_W         = 4;
    localparam int unsigned DEF_STROBE    = 2;
    localparam int unsigned DEF_GAP       = 1;
    localparam logic [3:0]  LANES_OFF     = 4'hf;
    localparam logic [3:0]  LANES_ALL     = 4'h0;
    typedef enum logic [2:0] {
        VARIABLE_LATENCY_IO_IDLE, VARIABLE_LATENCY_IO_LEAD, VARIABLE_LATENCY_IO_STROBE, VARIABLE_LATENCY_IO_END, VARIABLE_LATENCY_IO_GAP, VARIABLE_LATENCY_IO_HOLD
    } variable_latency_io_state_t;
endpackage : variable_latency_io_pkg
`default_nettype wire

// [rtl/variable_latency_io_port.sv]
// Variable latency io port: ready-gated static memory master
`default_nettype none
module variable_latency_io_port #(
    parameter int unsigned STROBE_COUNT = variable_latency_io_pkg::DEF_STROBE,
    parameter int unsigned GAP_COUNT    = variable_latency_io_pkg::DEF_GAP
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    input  wire logic                        i_req,
    input  wire logic                        i_write,
    input  wire logic                        i_wide,
    input  wire logic [variable_latency_io_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [variable_latency_io_pkg::LEN_W-1:0]  i_beats,
    input  wire logic [31:0]                 i_wdata,
    input  wire logic [3:0]                  i_lanes,
    input  wire logic                        i_ready,
    input  wire logic [31:0]                 i_memory_data_bus,
    output logic                             o_busy,
    output logic                             o_beat_done,
    output logic [31:0]                      o_rdata,
    output logic                             o_region_select_n,
    output logic                             o_read_strobe_n,
    output logic                             o_write_strobe_n,
    output logic [3:0]                       o_lane_select_n,
    output logic [variable_latency_io_pkg::ADDR_W-1:0]      o_memory_address_bus,
    output logic [31:0]                      o_memory_data_bus,
    output logic                             o_data_oe_n
);
    import variable_latency_io_pkg::*;

    // Counts must fit the four-bit cycle counter
    if (STROBE_COUNT < 1 || STROBE_COUNT > 14
        || GAP_COUNT > 15) begin : g_bad_count
        $error("variable_latency_io_port: count parameter out of range");
    end

    localparam logic [CNT_W-1:0] WIDTH_MIN = CNT_W'(STROBE_COUNT + 1);
    localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(GAP_COUNT);
    localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(CS_LEAD_CYC - 1);

    logic        ready_meta;
    logic        ready_sync;
    variable_latency_io_state_t state;
    variable_latency_io_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] next_left;
    logic        wr;
    logic        next_wr;
    logic        wide;
    logic        next_wide;
    logic [3:0]  lanes;
    logic [3:0]  next_lanes;
    logic        next_busy;
    logic        next_beat_done;
    logic [31:0] next_rdata;
    logic        next_cs_n;
    logic        next_rd_n;
    logic        next_wr_n;
    logic [3:0]  next_lane_n;
    logic [ADDR_W-1:0] next_addr;
    logic [31:0] next_wdata;
    logic        next_oe_n;
    logic        captured;

    // Ready synchroniser
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ready_meta <= 1'b0;
            ready_sync <= 1'b0;
        end else begin
            ready_meta <= i_ready;
            ready_sync <= ready_meta;
        end
    end

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_left      = left;
        next_wr        = wr;
        next_wide      = wide;
        next_lanes     = lanes;
        next_busy      = o_busy;
        next_beat_done = 1'b0;
        next_rdata     = o_rdata;
        next_cs_n      = o_region_select_n;
        next_rd_n      = o_read_strobe_n;
        next_wr_n      = o_write_strobe_n;
        next_lane_n    = o_lane_select_n;
        next_addr      = o_memory_address_bus;
        next_wdata     = o_memory_data_bus;
        next_oe_n      = o_data_oe_n;
        captured       = 1'b0;
        case (state)
            VARIABLE_LATENCY_IO_IDLE: begin
                if (i_req) begin
                    next_state = VARIABLE_LATENCY_IO_LEAD;
                    next_busy  = 1'b1;
                    next_wr    = i_write;
                    next_wide  = i_wide;
                    next_left  = i_beats;
                    next_lanes = i_wide ? i_lanes : {2'b11, i_lanes[1:0]};
                    next_addr  = i_addr;
                    next_cs_n  = 1'b0;
                    next_lane_n = i_write ? next_lanes : LANES_ALL;
                    next_wdata = i_wdata;
                    next_oe_n  = ~i_write;
                    next_cnt   = '0;
                end
            end
            VARIABLE_LATENCY_IO_LEAD: begin
                next_cnt = cnt + 1'b1;
                if (cnt >= LEAD_LAST) begin
                    next_state = VARIABLE_LATENCY_IO_STROBE;
                    next_cnt   = CNT_W'(1);
                    next_rd_n  = wr;
                    next_wr_n  = ~wr;
                end
            end
            VARIABLE_LATENCY_IO_STROBE: begin
                if (cnt < WIDTH_MIN)
                    next_cnt = cnt + 1'b1;
                if (ready_sync && cnt >= WIDTH_MIN) begin
                    captured       = 1'b1;
                    next_rdata     = wide ? i_memory_data_bus
                                          : {16'h0000,
                                             i_memory_data_bus[15:0]};
                    next_beat_done = 1'b1;
                    next_state     = VARIABLE_LATENCY_IO_END;
                end
            end
            VARIABLE_LATENCY_IO_END: begin
                next_rd_n = 1'b1;
                next_wr_n = 1'b1;
                next_cnt  = '0;
                if (left > LEN_W'(1)) begin
                    next_left  = left - 1'b1;
                    next_addr  = o_memory_address_bus
                               + (wide ? ADDR_W'(4) : ADDR_W'(2));
                    next_state = VARIABLE_LATENCY_IO_GAP;
                end else begin
                    next_state = VARIABLE_LATENCY_IO_HOLD;
                end
            end
            VARIABLE_LATENCY_IO_GAP: begin
                next_cnt = cnt + 1'b1;
                if (cnt >= GAP_LAST) begin
                    next_state = VARIABLE_LATENCY_IO_STROBE;
                    next_cnt   = CNT_W'(1);
                    next_rd_n  = wr;
                    next_wr_n  = ~wr;
                end
            end
            VARIABLE_LATENCY_IO_HOLD: begin
                next_cs_n   = 1'b1;
                next_lane_n = LANES_OFF;
                next_oe_n   = 1'b1;
                next_busy   = 1'b0;
                next_state  = VARIABLE_LATENCY_IO_IDLE;
            end
            default: next_state = VARIABLE_LATENCY_IO_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state                <= VARIABLE_LATENCY_IO_IDLE;
            cnt                  <= '0;
            left                 <= '0;
            wr                   <= 1'b0;
            wide                 <= 1'b0;
            lanes                <= LANES_OFF;
            o_busy               <= 1'b0;
            o_beat_done          <= 1'b0;
            o_rdata              <= '0;
            o_region_select_n    <= 1'b1;
            o_read_strobe_n      <= 1'b1;
            o_write_strobe_n     <= 1'b1;
            o_lane_select_n      <= LANES_OFF;
            o_memory_address_bus <= '0;
            o_memory_data_bus    <= '0;
            o_data_oe_n          <= 1'b1;
        end else begin
            state                <= next_state;
            cnt                  <= next_cnt;
            left                 <= next_left;
            wr                   <= next_wr;
            wide                 <= next_wide;
            lanes                <= next_lanes;
            o_busy               <= next_busy;
            o_beat_done          <= next_beat_done;
            o_rdata              <= next_rdata;
            o_region_select_n    <= next_cs_n;
            o_read_strobe_n      <= next_rd_n;
            o_write_strobe_n     <= next_wr_n;
            o_lane_select_n      <= next_lane_n;
            o_memory_address_bus <= next_addr;
            o_memory_data_bus    <= next_wdata;
            o_data_oe_n          <= next_oe_n;
        end
    end

    // Checks
    wire strobe_on = ~o_read_strobe_n | ~o_write_strobe_n;

    sequence strobe_rise_s;
        $fell(o_read_strobe_n & o_write_strobe_n);
    endsequence

    sequence strobe_drop_s;
        $rose(o_read_strobe_n & o_write_strobe_n);
    endsequence

    ready_sync_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ready_sync == $past(i_ready, 2) || $past(i_srst, 2) || $past(i_srst))
        else $error("ready not delayed by two flops");

    capture_cond_a: assert property (
        @(posedge i_clk) disable iff (i_srst)
        captured |-> ready_sync && cnt >= WIDTH_MIN)
        else $error("capture without ready or width");

    beat_width_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_beat_done |-> $past(ready_sync)
            && $past(strobe_on, STROBE_COUNT + 1))
        else $error("beat taken before minimum width");

    min_width_a: assert property (@(posedge i_clk) disable iff (i_srst)
        strobe_rise_s |-> strobe_on [*2])
        else $error("strobe narrower than minimum");

    strobe_drop_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_beat_done |=> strobe_drop_s)
        else $error("strobe not dropped one cycle after capture");

    sample_both_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (state == VARIABLE_LATENCY_IO_STROBE && !ready_sync) |=> !o_beat_done)
        else $error("beat finished without ready");

    gap_len_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (strobe_rise_s and ##0 ($past(state) == VARIABLE_LATENCY_IO_GAP))
            |-> $past(strobe_on, GAP_COUNT + 2)
                && !$past(strobe_on, GAP_COUNT + 1))
        else $error("beat gap not gap count plus one");

    select_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (strobe_drop_s and ##0 (state == VARIABLE_LATENCY_IO_HOLD))
            |-> !o_region_select_n ##1 o_region_select_n)
        else $error("select not held one cycle after burst");

    lead_cs_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_region_select_n) |-> !strobe_on ##1 !strobe_on)
        else $error("strobe too soon after select");

    addr_stable_a: assert property (@(posedge i_clk) disable iff (i_srst)
        strobe_on |-> $stable(o_memory_address_bus))
        else $error("address moved under strobe");

    read_lanes_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_read_strobe_n |-> o_lane_select_n == LANES_ALL)
        else $error("byte selects wrong on read");
endmodule : variable_latency_io_port
`default_nettype wire

// [tb/variable_latency_io_periph.sv]
// Behavioural peripheral answering the variable latency io port
`default_nettype none
module variable_latency_io_periph (
    input  wire logic        i_clk,
    input  wire logic        i_read_strobe_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic [25:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wait,
    output logic             o_ready,
    output logic [31:0]      o_rdata,
    output logic [31:0]      o_last_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        act;
    logic [3:0]  cnt;
    logic [31:0] pat;
    assign act = !(i_read_strobe_n && i_write_strobe_n);
    assign pat = {~i_addr[15:0], i_addr[15:0] ^ 16'h5a5a};
    // Ready after the wait, gone once the strobe is released
    assign o_ready = act && (cnt >= i_wait);
    // Data held while read strobe low, scrambled otherwise
    assign o_rdata = i_read_strobe_n ? ~pat : pat;
    always @(posedge i_clk) begin
        cnt <= act ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        if (!i_write_strobe_n) begin
            o_last_wdata <= i_wdata;
        end
    end
endmodule : variable_latency_io_periph
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the variable latency io port
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import variable_latency_io_pkg::*;
    localparam int SC = 3;
    localparam int GC = 2;
    logic        clk, busy, bd, sel_n, rs_n, ws_n, oe_n, rdy;
    logic        srst = 1'b1, req = 1'b0, wr = 1'b0, wide = 1'b0;
    logic [25:0] addr = 26'h0, ma;
    logic [3:0]  beats = 4'h0, lanes = 4'hf, wt = 4'h0, lsn;
    logic [31:0] wd = 32'h0, md, rd, mdo, lwd;
    int          errors = 0, num_checks = 0;
    variable_latency_io_port #(.STROBE_COUNT(SC), .GAP_COUNT(GC)) uut (
        .i_clk(clk), .i_srst(srst), .i_req(req), .i_write(wr),
        .i_wide(wide), .i_addr(addr), .i_beats(beats), .i_wdata(wd),
        .i_lanes(lanes), .i_ready(rdy), .i_memory_data_bus(md),
        .o_busy(busy), .o_beat_done(bd), .o_rdata(rd),
        .o_region_select_n(sel_n), .o_read_strobe_n(rs_n),
        .o_write_strobe_n(ws_n), .o_lane_select_n(lsn),
        .o_memory_address_bus(ma), .o_memory_data_bus(mdo),
        .o_data_oe_n(oe_n));
    variable_latency_io_periph p (.i_clk(clk), .i_read_strobe_n(rs_n),
        .i_write_strobe_n(ws_n), .i_addr(ma), .i_wdata(mdo), .i_wait(wt),
        .o_ready(rdy), .o_rdata(md), .o_last_wdata(lwd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // One burst, judged cycle by cycle at the falling edge
    task automatic run(input logic w, input logic wi, input logic [25:0] a,
        input logic [3:0] n, input logic [3:0] ln, input logic [3:0] wc,
        input logic [31:0] dt);
        int k, lo, hi, sl, nb, nbt;
        logic [25:0] ea;
        logic [31:0] ex;
        logic st, pr, dn;
        logic [3:0] el;
        int ew;
        {lo, hi, sl, nb, pr, dn, ea} = {32'h0, 32'h0, 32'h0, 32'h0, 2'b10, a};
        nbt = (n == 0) ? 1 : int'(n);
        el = w ? (wi ? ln : {2'b11, ln[1:0]}) : 4'h0;
        ew = (SC + 1 > int'(wc) + 3 ? SC + 1 : int'(wc) + 3) + 1;
        @(negedge clk);
        {wr, wide, addr, beats, lanes, wt, wd} = {w, wi, a, n, ln, wc, dt};
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        for (k = 0; k < 300 && (busy || k < 2); k++) begin
            st = rs_n & ws_n;
            if (dn) `CHK("strobe_drop", 1'b1, st)
            dn = 1'b0;
            if (st && !pr && nb == nbt) `CHK("sel_last", 1'b0, sel_n)
            if (!st && pr && nb > 0) `CHK("gap", GC + 1, hi)
            if (!st && pr && nb == 0) `CHK("lead", 1, int'(sl >= 2))
            hi = st ? hi + 1 : 0;
            lo = st ? 0 : lo + 1;
            sl = sl + int'(!sel_n && st);
            if (!st) begin
                `CHK("dir", w ? 2'b10 : 2'b01, {rs_n, ws_n})
                `CHK("oe", !w, oe_n)
                `CHK("lanes", el, lsn)
                `CHK("addr", ea, ma)
            end
            if (bd) begin
                `CHK("width", ew, lo)
                ex = {~ea[15:0], ea[15:0] ^ 16'h5a5a};
                if (!wi) ex = {16'h0000, ex[15:0]};
                if (!w) `CHK("rdata", ex, rd)
                ea = ea + (wi ? 26'h4 : 26'h2);
                nb++;
                dn = 1'b1;
            end
            pr = st;
            @(negedge clk);
        end
        if (k == 300) begin
            errors++;
            results();
        end
        `CHK("sel_off", 1'b1, sel_n)
        `CHK("beats", nbt, nb)
        if (w) `CHK("wdata", wi ? dt : dt[15:0], wi ? lwd : lwd[15:0])
    endtask : run
    task automatic sc_read_burst;
        run(1'b0, 1'b1, 26'h100, 4'h3, 4'h0, 4'h0, 32'h0);
    endtask : sc_read_burst
    task automatic sc_write_narrow;
        run(1'b1, 1'b0, 26'h222, 4'h2, 4'ha, 4'h0, 32'h1234abcd);
    endtask : sc_write_narrow
    task automatic sc_read_slow;
        run(1'b0, 1'b0, 26'h3f0, 4'h2, 4'h0, 4'h5, 32'h0);
    endtask : sc_read_slow
    task automatic sc_write_slow;
        run(1'b1, 1'b1, 26'h40, 4'h0, 4'h5, 4'h3, 32'hcafe0123);
    endtask : sc_write_slow
    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        `CHK("rst_sel", 1'b1, sel_n)
        `CHK("rst_strobe", 2'b11, {rs_n, ws_n})
        `CHK("rst_lanes", 4'hf, lsn)
        sc_read_burst();
        sc_write_narrow();
        sc_read_slow();
        sc_write_slow();
        results();
    end
endmodule : testbench
`default_nettype wire
